// *** hw/tsf_fifo.v ***
// sample store: fifo with rollover, writable read index and flush
`default_nettype none
module tsf_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 32,
	parameter AW    = 5,
	parameter CW    = 6
) (
	input  wire             mclk,
	input  wire             rstn,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output reg  [WIDTH-1:0] out_data,
	input  wire             rollover,
	input  wire             flush,
	input  wire             rd_load,
	input  wire [AW-1:0]    rd_load_index,
	output reg  [AW-1:0]    wr_index,
	output reg  [AW-1:0]    rd_index,
	output reg  [CW-1:0]    count,
	output wire             push,
	output wire             lost,
	output wire             pop
);
	localparam [CW-1:0] DEPTH_C = DEPTH[CW-1:0];
	localparam [AW-1:0] ONE_A   = 1;
	localparam [CW-1:0] ONE_C   = 1;

	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    rd_nxt;
	reg  [CW-1:0]    count_nxt;
	wire             full_eff;
	wire             ovr;

	assign pop       = out_valid & out_ready;
	// a pop in the same cycle frees a slot, so no loss then
	assign full_eff  = (count == DEPTH_C) & ~pop;
	assign in_ready  = ~full_eff | rollover;
	assign push      = in_valid & in_ready & ~flush;
	assign ovr       = push & full_eff; // RULE6
	assign lost      = in_valid & full_eff & ~flush; // RULE7
	assign out_valid = (count != {CW{1'b0}});

	always @* begin
		rd_nxt = rd_index;
		if (flush)
			rd_nxt = {AW{1'b0}}; // RULE12
		else if (rd_load)
			rd_nxt = rd_load_index; // RULE14
		else if (pop | ovr)
			rd_nxt = rd_index + ONE_A;
	end

	always @* begin
		count_nxt = count;
		if (flush)
			count_nxt = {CW{1'b0}}; // RULE12
		else if ((push & ~ovr) & ~pop)
			count_nxt = count + ONE_C; // RULE16
		else if (pop & ~(push & ~ovr))
			count_nxt = count - ONE_C; // RULE17
	end

	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wr_index <= {AW{1'b0}};
			rd_index <= {AW{1'b0}};
			count    <= {CW{1'b0}};
		end else begin
			rd_index <= rd_nxt;
			count    <= count_nxt;
			if (flush)
				wr_index <= {AW{1'b0}}; // RULE12
			else if (push)
				wr_index <= wr_index + ONE_A; // RULE13
		end
	end

	always @(posedge mclk) begin
		if (push)
			mem[wr_index] <= in_data;
	end

	// registered head word; bypass so a fresh write is seen at once
	always @(posedge mclk or negedge rstn) begin
		if (!rstn)
			out_data <= {WIDTH{1'b0}};
		else if (push && (wr_index == rd_nxt))
			out_data <= in_data;
		else
			out_data <= mem[rd_nxt];
	end
endmodule
`default_nettype wire

// *** hw/tsf_top.v ***
// temperature sample fifo with its byte register port and flag logic
`default_nettype none
`include "tsf_defines.vh"
module tsf_top #(
	parameter DEPTH = `TSF_DEPTH,
	parameter WIDTH = `TSF_WIDTH
) (
	input  wire             mclk,
	input  wire             rstn,
	input  wire             sample_valid,
	output wire             sample_ready,
	input  wire [WIDTH-1:0] sample_data,
	input  wire [7:0]       reg_addr,
	input  wire             reg_wr,
	input  wire [7:0]       reg_wdata,
	input  wire             reg_rd,
	output reg  [7:0]       reg_rdata_r,
	input  wire [1:0]       pin0_function_select,
	output wire             pin0
);
	reg  [7:0] enables_r;
	reg  [4:0] watermark_r;
	reg  [2:0] policy_r;
	reg        afull_r;
	reg        afull_cond_r;
	reg        byte_phase_r;
	reg  [4:0] lost_word_count_r;
	reg  [7:0] rdata_nxt;
	reg        afull_nxt;
	reg  [4:0] lost_nxt;

	wire [4:0] write_index;
	wire [4:0] read_index;
	wire [5:0] stored_count;
	wire [WIDTH-1:0] head_word;
	wire       push;
	wire       lost;
	wire       pop;
	wire       rollover_enable;
	wire       afull_type;
	wire       clear_flag_on_data_read;
	wire       wr_policy;
	wire       flush;
	wire       rd_port;
	wire       pop_req;
	wire       status_rd;
	wire [5:0] afull_level;
	wire       afull_cond;
	wire       afull_set;
	wire       afull_clr;
	wire [5:0] depth_c;

	assign depth_c = DEPTH[5:0];
	assign rollover_enable         = policy_r[0];
	assign afull_type              = policy_r[1];
	assign clear_flag_on_data_read = policy_r[2];

	assign wr_policy = reg_wr & (reg_addr == `TSF_ADDR_POLICY);
	// takes effect at the very edge of the register write
	assign flush     = wr_policy & reg_wdata[`TSF_BIT_FLUSH]; // RULE12 RULE17
	assign rd_port   = reg_rd & (reg_addr == `TSF_ADDR_READ_PORT);
	assign pop_req   = rd_port & byte_phase_r; // RULE14
	assign status_rd = reg_rd & (reg_addr == `TSF_ADDR_EVENT_FLAGS);

	tsf_fifo #(
		.WIDTH (WIDTH),
		.DEPTH (DEPTH),
		.AW    (5),
		.CW    (6)
	) u_store (
		.mclk          (mclk),
		.rstn          (rstn),
		.in_valid      (sample_valid),
		.in_ready      (sample_ready),
		.in_data       (sample_data),
		.out_valid     (),
		.out_ready     (pop_req),
		.out_data      (head_word),
		.rollover      (rollover_enable),
		.flush         (flush),
		.rd_load       (reg_wr & (reg_addr == `TSF_ADDR_READ_INDEX)),
		.rd_load_index (reg_wdata[4:0]),
		.wr_index      (write_index),
		.rd_index      (read_index),
		.count         (stored_count),
		.push          (push),
		.lost          (lost),
		.pop           (pop)
	);

	// level reached after this cycle's push
	assign afull_level = depth_c - {1'b0, watermark_r};
	assign afull_cond  = (stored_count >= afull_level) |
		(push & ((stored_count + 6'h01) >= afull_level)); // RULE4
	// type 0 re-flags on every push; type 1 only on a fresh rise
	assign afull_set = push & afull_cond &
		(~afull_type | ~afull_cond_r); // RULE8 RULE9
	assign afull_clr = status_rd |
		(clear_flag_on_data_read & rd_port); // RULE10 RULE11

	always @* begin
		afull_nxt = afull_r;
		if (afull_set)
			afull_nxt = 1'b1;
		else if (afull_clr)
			afull_nxt = 1'b0;
	end

	// no loss can occur in the same cycle as a pop, so a pop clears the count
	always @* begin
		lost_nxt = lost_word_count_r;
		if (flush)
			lost_nxt = 5'h00; // RULE12
		else if (pop)
			lost_nxt = lost ? 5'h01 : 5'h00; // RULE15
		else if (lost && lost_word_count_r != `TSF_LOST_MAX)
			lost_nxt = lost_word_count_r + 5'h01; // RULE15
	end

	always @* begin
		rdata_nxt = 8'h00;
		case (reg_addr)
		`TSF_ADDR_EVENT_FLAGS:   rdata_nxt = {afull_r, 7'h00};
		`TSF_ADDR_EVENT_ENABLES: rdata_nxt = enables_r;
		`TSF_ADDR_WRITE_INDEX:   rdata_nxt = {3'h0, write_index};
		`TSF_ADDR_READ_INDEX:    rdata_nxt = {3'h0, read_index};
		`TSF_ADDR_LOST_COUNT:    rdata_nxt = {3'h0, lost_word_count_r};
		`TSF_ADDR_STORED_COUNT:  rdata_nxt = {2'h0, stored_count};
		`TSF_ADDR_READ_PORT:     rdata_nxt = byte_phase_r ?
			head_word[7:0] : head_word[15:8]; // RULE1
		`TSF_ADDR_WATERMARK:     rdata_nxt = {3'h0, watermark_r};
		`TSF_ADDR_POLICY:        rdata_nxt = {4'h0, policy_r, 1'b0};
		default:                 rdata_nxt = 8'h00;
		endcase
	end

	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			enables_r         <= `TSF_RST_ENABLES;
			watermark_r       <= `TSF_RST_WATERMARK;
			policy_r          <= `TSF_RST_POLICY;
			afull_r           <= 1'b0;
			afull_cond_r      <= 1'b0;
			byte_phase_r      <= 1'b0;
			lost_word_count_r <= 5'h00;
			reg_rdata_r       <= 8'h00;
		end else begin
			afull_r           <= flush ? 1'b0 : afull_nxt;
			afull_cond_r      <= flush ? 1'b0 : afull_cond;
			lost_word_count_r <= lost_nxt;
			if (reg_rd)
				reg_rdata_r <= rdata_nxt;
			// any other access breaks a byte pair
			if (rd_port)
				byte_phase_r <= ~byte_phase_r; // RULE1
			else if (reg_rd | reg_wr)
				byte_phase_r <= 1'b0;
			if (reg_wr && reg_addr == `TSF_ADDR_EVENT_ENABLES)
				enables_r <= reg_wdata;
			if (reg_wr && reg_addr == `TSF_ADDR_WATERMARK)
				watermark_r <= reg_wdata[4:0];
			if (wr_policy)
				policy_r <= {reg_wdata[`TSF_BIT_CLR_ON_DATA],
					reg_wdata[`TSF_BIT_AFULL_TYPE],
					reg_wdata[`TSF_BIT_ROLLOVER]};
		end
	end

	// no register stage: follows the flag in the same cycle
	assign pin0 = afull_r & enables_r[`TSF_BIT_AFULL] &
		(pin0_function_select == `TSF_PIN0_IRQ_MODE); // RULE5 RULE18
endmodule
`default_nettype wire

// *** pkg/tsf_defines.vh ***
// constants for the temperature sample fifo and its registers
// What this block does
// RULE1 - word read as high byte then low byte
// RULE2 - master reads lost count before data count
// RULE3 - master may use index difference when no loss
// RULE4 - almost-full at depth minus watermark words
// RULE5 - almost-full interrupt drives pin0 in mode 3
// RULE6 - rollover overwrites oldest entry when full
// RULE7 - no rollover: new sample dropped when full
// RULE8 - type 0: flag reasserts each sample
// RULE9 - type 1: flag sets on new condition only
// RULE10 - clear option 0: only status read clears
// RULE11 - clear option 1: data or status read clears
// RULE12 - flush empties fifo and self-clears
// RULE13 - write index advances per push and wraps
// RULE14 - two byte reads pop; read index writable
// RULE15 - lost words counted, saturate, cleared on pop
// RULE16 - six-bit stored word count up and down
// RULE17 - flush in one clock; push plus pop holds
// RULE18 - interrupt is plain and of flag, enable, mode
`ifndef TSF_DEFINES_VH
`define TSF_DEFINES_VH

`define TSF_ADDR_EVENT_FLAGS     8'h00
`define TSF_ADDR_EVENT_ENABLES   8'h01
`define TSF_ADDR_WRITE_INDEX     8'h04
`define TSF_ADDR_READ_INDEX      8'h05
`define TSF_ADDR_LOST_COUNT      8'h06
`define TSF_ADDR_STORED_COUNT    8'h07
`define TSF_ADDR_READ_PORT       8'h08
`define TSF_ADDR_WATERMARK       8'h09
`define TSF_ADDR_POLICY          8'h0A

`define TSF_BIT_AFULL            7
`define TSF_BIT_FLUSH            4
`define TSF_BIT_CLR_ON_DATA      3
`define TSF_BIT_AFULL_TYPE       2
`define TSF_BIT_ROLLOVER         1

`define TSF_RST_ENABLES          8'h00
`define TSF_RST_WATERMARK        5'h00
`define TSF_RST_POLICY           3'h0

`define TSF_DEPTH                32
`define TSF_WIDTH                16
`define TSF_LOST_MAX             5'h1F
`define TSF_PIN0_IRQ_MODE        2'h3

`endif

// *** tb/tsf_checker.sv ***
// concurrent checks on the sample fifo ports
`default_nettype none
module tsf_checker #(
	parameter int DEPTH = 32,
	parameter int WIDTH = 16
) (
	input wire logic             mclk,
	input wire logic             rstn,
	input wire logic             sample_valid,
	input wire logic             sample_ready,
	input wire logic [WIDTH-1:0] sample_data,
	input wire logic [7:0]       reg_addr,
	input wire logic             reg_wr,
	input wire logic [7:0]       reg_wdata,
	input wire logic             reg_rd,
	input wire logic [7:0]       reg_rdata_r,
	input wire logic [1:0]       pin0_function_select,
	input wire logic             pin0
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence flush_s;
		reg_wr && reg_addr == 8'h0A && reg_wdata[4] && !sample_valid;
	endsequence
	sequence count_rd_s;
		!sample_valid ##1 reg_rd && reg_addr == 8'h07;
	endsequence
	reset_quiet_a: assert property (
		disable iff (1'b0)
		!rstn |-> !reg_rdata_r && !pin0 && sample_ready)
		else $error("outputs not quiet in reset");
	pin_mode_a: assert property (
		pin0 |-> pin0_function_select == 2'h3)
		else $error("pin0 high outside interrupt mode");
	flag_keep_a: assert property (
		pin0 && !reg_rd && !reg_wr ##1 pin0_function_select == 2'h3
		|-> pin0)
		else $error("flag dropped without a read");
	rdata_hold_a: assert property (
		!reg_rd |=> $stable(reg_rdata_r))
		else $error("read byte changed without a read");
	flush_zero_a: assert property (
		flush_s ##1 count_rd_s |=> reg_rdata_r == 8'h00)
		else $error("count not zero after flush");
	self_clear_a: assert property (
		reg_rd && reg_addr == 8'h0A |=> reg_rdata_r[7:4] == 4'h0)
		else $error("flush bit read back set");
	count_max_a: assert property (
		reg_rd && reg_addr == 8'h07 |=> reg_rdata_r <= DEPTH)
		else $error("stored count above depth");
	index_wide_a: assert property (
		reg_rd && reg_addr inside {8'h04, 8'h05, 8'h06}
		|=> reg_rdata_r[7:5] == 3'h0)
		else $error("index or lost count too wide");
endmodule
bind tsf_top tsf_checker #(.DEPTH(DEPTH), .WIDTH(WIDTH)) u_chk (
	.mclk(mclk), .rstn(rstn), .sample_valid(sample_valid),
	.sample_ready(sample_ready), .sample_data(sample_data),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
	.reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .pin0(pin0),
	.pin0_function_select(pin0_function_select));
`default_nettype wire

// *** tb/tsf_master.sv ***
// bus master model: byte register reads and writes
`default_nettype none
module tsf_master (
	input  wire logic       mclk,
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata_r
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	// idle cycle after each access so strobes never toggle twice at once
	task automatic wr(input logic [7:0] a, d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge mclk) #1;
		reg_wr = 1'b0;
		@(posedge mclk) #1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge mclk) #1;
		d = reg_rdata_r;
		reg_rd = 1'b0;
		@(posedge mclk) #1;
	endtask
	// lost count first: any loss means every slot holds data
	task automatic avail(output logic [7:0] n);
		logic [7:0] l;
		rd(8'h06, l);
		rd(8'h07, n);
		if (l !== 8'h00) n = 8'h20;
	endtask
	// index difference wraps at 32; only trusted while nothing was lost
	task automatic avail_idx(output logic [7:0] n);
		logic [7:0] l, w, r;
		rd(8'h06, l);
		rd(8'h04, w);
		rd(8'h05, r);
		n = {3'h0, w[4:0] - r[4:0]};
		if (l !== 8'h00) n = 8'h20;
	endtask
endmodule
`default_nettype wire

// *** tb/tsf_top_test.sv ***
// self-checking bench for the temperature sample fifo
`default_nettype none
module tsf_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 1'b0;
	logic        rstn = 1'b1;
	logic        sample_valid = 1'b0;
	logic [15:0] sample_data = 16'h0000;
	logic [1:0]  mode = 2'h0;
	logic [7:0]  k = 8'h00;
	logic [7:0]  v;
	int          error_cnt = 0;
	int          total_checks = 0;
	wire         sample_ready, pin0, reg_wr, reg_rd;
	wire  [7:0]  reg_addr, reg_wdata, reg_rdata_r;
	// address in the high byte, expected read in the low byte
	logic [15:0] rows [9] = '{16'h0000, 16'h0100, 16'h0400, 16'h0500,
		16'h0600, 16'h0700, 16'h0900, 16'h0A00, 16'h3000};
	always #10 mclk = ~mclk;
	tsf_top i_dut (.mclk(mclk), .rstn(rstn), .sample_valid(sample_valid),
		.sample_ready(sample_ready), .sample_data(sample_data),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
		.pin0_function_select(mode), .pin0(pin0));
	tsf_master m (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r));
	task automatic chk(input logic [7:0] s, e);
		total_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h wanted %h", $time, s, e);
		end
	endtask
	task automatic rc(input logic [7:0] a, e);
		m.rd(a, v);
		chk(v, e);
	endtask
	// sample k carries ~k in its high byte and k in its low byte
	task automatic push(input int n);
		sample_valid = 1'b1;
		repeat (n) begin
			sample_data = {~k, k};
			@(posedge mclk) #1;
			k++;
		end
		sample_valid = 1'b0;
		@(posedge mclk) #1;
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge mclk);
		error_cnt++;
		report_and_stop;
	end
	initial begin
		// a real falling edge, so outputs are cleared before the first clock
		#1 rstn = 1'b0;
		repeat (20) @(posedge mclk);
		#1 rstn = 1'b1;
		foreach (rows[i]) rc(rows[i][15:8], rows[i][7:0]);
		$display("reset test done");
		push(3);
		rc(8'h07, 8'h03);
		rc(8'h04, 8'h03);
		rc(8'h08, 8'hFF);
		rc(8'h08, 8'h00);
		m.avail_idx(v);
		chk(v, 8'h02);
		m.wr(8'h05, 8'h00);
		rc(8'h08, 8'hFF);
		rc(8'h08, 8'h00);
		m.avail(v);
		chk(v, 8'h01);
		m.wr(8'h0A, 8'h10);
		rc(8'h07, 8'h00);
		foreach (rows[i]) if (i > 1) rc(rows[i][15:8], 8'h00);
		$display("order and flush test done");
		k = 8'h00;
		m.wr(8'h09, 8'h02);
		m.wr(8'h01, 8'h80);
		mode = 2'h3;
		push(29);
		rc(8'h00, 8'h00);
		push(1);
		chk({7'h00, pin0}, 8'h01);
		rc(8'h00, 8'h80);
		rc(8'h00, 8'h00);
		push(1);
		rc(8'h00, 8'h80);
		m.wr(8'h0A, 8'h04);
		push(1);
		rc(8'h00, 8'h00);
		chk({7'h00, sample_ready}, 8'h00);
		push(2);
		rc(8'h06, 8'h02);
		rc(8'h04, 8'h00);
		// enough further losses to reach the ceiling
		push(30);
		rc(8'h06, 8'h1F);
		m.avail_idx(v);
		chk(v, 8'h20);
		m.wr(8'h0A, 8'h06);
		push(1);
		rc(8'h04, 8'h01);
		rc(8'h06, 8'h1F);
		rc(8'h07, 8'h20);
		rc(8'h08, 8'hFE);
		rc(8'h08, 8'h01);
		rc(8'h06, 8'h00);
		$display("full test done");
		m.wr(8'h0A, 8'h00);
		push(1);
		mode = 2'h2;
		@(posedge mclk) #1;
		chk({7'h00, pin0}, 8'h00);
		mode = 2'h3;
		rc(8'h08, 8'hFD);
		rc(8'h08, 8'h02);
		rc(8'h00, 8'h80);
		m.wr(8'h0A, 8'h08);
		push(1);
		rc(8'h08, 8'hFC);
		rc(8'h08, 8'h03);
		rc(8'h00, 8'h00);
		$display("clear option test done");
		rc(8'h08, 8'hFB);
		// low byte pop and a new sample meet at one edge
		fork
			push(1);
			rc(8'h08, 8'h04);
		join
		rc(8'h07, 8'h1F);
		$display("push with pop test done");
		rstn = 1'b0;
		repeat (2) @(posedge mclk);
		#1 rstn = 1'b1;
		foreach (rows[i]) rc(rows[i][15:8], rows[i][7:0]);
		$display("mid-run reset test done");
		report_and_stop;
	end
endmodule
`default_nettype wire
